// *** include/vic_pkg.sv ***
package vic_pkg;
	localparam int unsigned NUM_SRC     = 15;
	localparam int unsigned NUM_MASK    = 14;
	localparam int unsigned LVL_W       = 4;
	localparam logic [15:0] VEC_WDT     = 16'h0004;
	localparam logic [15:0] VEC_PIN0    = 16'h0006;
	localparam logic [15:0] VEC_PIN1    = 16'h0008;
	localparam logic [15:0] VEC_PIN2    = 16'h000a;
	localparam logic [15:0] VEC_PIN3    = 16'h000c;
	localparam logic [15:0] VEC_SER     = 16'h000e;
	localparam logic [15:0] VEC_TX      = 16'h0012;
	localparam logic [15:0] VEC_WTI     = 16'h0014;
	localparam logic [15:0] VEC_TM16    = 16'h0016;
	localparam logic [15:0] VEC_TM8A    = 16'h0018;
	localparam logic [15:0] VEC_TM8B    = 16'h001a;
	localparam logic [15:0] VEC_ADC     = 16'h001c;
	localparam logic [15:0] VEC_WT      = 16'h001e;
	localparam logic [15:0] VEC_KEY     = 16'h0020;
	localparam logic [1:0]  EDGE_NONE   = 2'h0;
	localparam logic [1:0]  EDGE_RISE   = 2'h1;
	localparam logic [1:0]  EDGE_FALL   = 2'h2;
	localparam logic [1:0]  EDGE_BOTH   = 2'h3;
	localparam logic [13:0] PEND_RST    = 14'h0000;
	localparam logic [15:0] VEC_RST     = 16'h0000;
	localparam logic [1:0]  SYNC_RST    = 2'h0;
	typedef enum logic [1:0]
	{
		VIC_IDLE = 2'b00,
		VIC_GRANT = 2'b01,
		VIC_SERVE = 2'b11
	} vic_state_t;
endpackage : vic_pkg

// *** rtl/vic_edge_det.sv ***
module vic_edge_det
(
	input  wire logic       core_clk_i, // Core clock
	input  wire logic       rstn_i,     // Async reset, active low
	input  wire logic       pin_i,      // Raw pin level
	input  wire logic [1:0] edge_sel_i, // Valid edge select
	output logic            det_o       // One-cycle edge pulse
);
	logic [1:0] sync;
	logic       prev;
	logic [1:0] next_sync;
	logic       next_prev;
	logic       rise;
	logic       fall;

	always_comb
	begin
		next_sync = {sync[0], pin_i};
		next_prev = sync[1];
		rise      = sync[1] & ~prev;
		fall      = ~sync[1] & prev;
		case (edge_sel_i)
			vic_pkg::EDGE_RISE: det_o = rise;
			vic_pkg::EDGE_FALL: det_o = fall;
			vic_pkg::EDGE_BOTH: det_o = rise | fall;
			default:            det_o = 1'b0;
		endcase
	end

	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			sync <= vic_pkg::SYNC_RST;
			prev <= 1'b0;
		end
		else
		begin
			sync <= next_sync;
			prev <= next_prev;
		end
	end
endmodule : vic_edge_det

// *** rtl/vic_ctrl.sv ***
module vic_ctrl
(
	input  wire logic       core_clk_i,      // Core clock, 250 MHz
	input  wire logic       rstn_i,          // Async reset, active low
	input  wire logic       wdt_overflow_i,  // Watchdog overflow pulse
	input  wire logic       wdt_nmi_mode_i,  // 1: watchdog mode 1, 0: interval
	input  wire logic [3:0] ext_pin_i,       // External interrupt pins
	input  wire logic [7:0] ext_edge_sel_i,  // Two bits per pin edge select
	input  wire logic [3:0] key_input_pins_i, // Key input pins
	input  wire logic       serial_rx_done_i, // UART receive done
	input  wire logic       serial_3wire_done_i, // 3-wire transfer done
	input  wire logic       serial_tx_done_i, // UART transmit done
	input  wire logic       watch_interval_i, // Watch interval event
	input  wire logic       watch_main_i,    // Watch main event
	input  wire logic       timer16_match_i, // 16-bit timer match
	input  wire logic       timer8a_match_i, // First 8-bit timer match
	input  wire logic       timer8b_match_i, // Second 8-bit timer match
	input  wire logic       adc_done_i,      // A/D conversion done
	input  wire logic       ie_set_i,        // Set global enable
	input  wire logic       ie_clr_i,        // Clear global enable
	input  wire logic       ack_i,           // CPU took the grant
	input  wire logic       eos_i,           // CPU end of service
	output logic            irq_o,           // Grant request to CPU
	output logic            irq_nmi_o,       // Granted request is NMI
	output logic [15:0]     vector_o,        // Vector table address
	output logic [3:0]      level_o,         // Granted maskable level
	output logic [13:0]     pending_o,       // Pending maskable requests
	output logic            global_irq_enable_flag_o,    // Global enable
	output logic            nonmaskable_in_service_flag_o // NMI in service
);
	logic [3:0]             pin_det;
	logic [3:0]             key_sync1;
	logic [3:0]             key_sync2;
	logic [3:0]             key_prev;
	logic                   key_det;
	logic                   watchdog_overflow_request;
	logic                   nmi_event;
	logic [13:0]            src_evt;
	logic [13:0]            pend;
	logic [13:0]            next_pend;
	logic                   nmi_pend;
	logic                   next_nmi_pend;
	logic                   ie;
	logic                   next_ie;
	logic                   nonmaskable_in_service_flag;
	logic                   next_nonmaskable_in_service_flag;
	logic                   mask_serv;
	logic                   next_mask_serv;
	vic_pkg::vic_state_t    state;
	vic_pkg::vic_state_t    next_state;
	logic                   gnt_nmi;
	logic                   next_gnt_nmi;
	logic [3:0]             gnt_lvl;
	logic [3:0]             next_gnt_lvl;
	logic [15:0]            vec;
	logic [15:0]            next_vec;
	logic [3:0]             win_lvl;
	logic                   win_any;
	logic [3:0]             next_key_sync1;

	function automatic logic [15:0] lvl_vector(input logic [3:0] lvl);
		case (lvl)
			4'h0:    lvl_vector = vic_pkg::VEC_WDT;
			4'h1:    lvl_vector = vic_pkg::VEC_PIN0;
			4'h2:    lvl_vector = vic_pkg::VEC_PIN1;
			4'h3:    lvl_vector = vic_pkg::VEC_PIN2;
			4'h4:    lvl_vector = vic_pkg::VEC_PIN3;
			4'h5:    lvl_vector = vic_pkg::VEC_SER;
			4'h6:    lvl_vector = vic_pkg::VEC_TX;
			4'h7:    lvl_vector = vic_pkg::VEC_WTI;
			4'h8:    lvl_vector = vic_pkg::VEC_TM16;
			4'h9:    lvl_vector = vic_pkg::VEC_TM8A;
			4'ha:    lvl_vector = vic_pkg::VEC_TM8B;
			4'hb:    lvl_vector = vic_pkg::VEC_ADC;
			4'hc:    lvl_vector = vic_pkg::VEC_WT;
			default: lvl_vector = vic_pkg::VEC_KEY;
		endcase
	endfunction : lvl_vector

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_pin
			vic_edge_det u_edge
			(
				.core_clk_i (core_clk_i),
				.rstn_i     (rstn_i),
				.pin_i      (ext_pin_i[gi]),
				.edge_sel_i (ext_edge_sel_i[2*gi+1:2*gi]),
				.det_o      (pin_det[gi])
			);
		end
	endgenerate

	// Key return: falling edge on any key pin
	always_comb
	begin
		next_key_sync1 = key_input_pins_i;
		key_det        = |(key_prev & ~key_sync2);
	end

	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			key_sync1 <= 4'h0;
			key_sync2 <= 4'h0;
			key_prev  <= 4'h0;
		end
		else
		begin
			key_sync1 <= next_key_sync1;
			key_sync2 <= key_sync1;
			key_prev  <= key_sync2;
		end
	end

	// Source mapping, index equals priority level
	always_comb
	begin
		watchdog_overflow_request = wdt_overflow_i & ~wdt_nmi_mode_i;
		nmi_event                 = wdt_overflow_i & wdt_nmi_mode_i;
		src_evt[0]  = watchdog_overflow_request;
		src_evt[4:1] = pin_det;
		src_evt[5]  = serial_rx_done_i | serial_3wire_done_i;
		src_evt[6]  = serial_tx_done_i;
		src_evt[7]  = watch_interval_i;
		src_evt[8]  = timer16_match_i;
		src_evt[9]  = timer8a_match_i;
		src_evt[10] = timer8b_match_i;
		src_evt[11] = adc_done_i;
		src_evt[12] = watch_main_i;
		src_evt[13] = key_det;
	end

	// Fixed priority: lowest index wins
	always_comb
	begin
		win_lvl = 4'h0;
		win_any = 1'b0;
		for (int i = vic_pkg::NUM_MASK - 1; i >= 0; i--)
		begin
			if (pend[i])
			begin
				win_lvl = 4'(i);
				win_any = 1'b1;
			end
		end
	end

	always_comb
	begin
		next_state     = state;
		next_pend      = pend;
		next_nmi_pend  = nmi_pend | nmi_event;
		next_ie        = ie;
		next_nonmaskable_in_service_flag      = nonmaskable_in_service_flag;
		next_mask_serv = mask_serv;
		next_gnt_nmi   = gnt_nmi;
		next_gnt_lvl   = gnt_lvl;
		next_vec       = vec;
		if (ie_clr_i)
			next_ie = 1'b0;
		if (ie_set_i)
			next_ie = 1'b1;
		case (state)
			vic_pkg::VIC_IDLE:
			begin
				if (nmi_pend && !nonmaskable_in_service_flag)
				begin
					next_state   = vic_pkg::VIC_GRANT;
					next_gnt_nmi = 1'b1;
					next_vec     = vic_pkg::VEC_WDT;
				end
				else if (win_any && ie && !mask_serv && !nonmaskable_in_service_flag)
				begin
					next_state   = vic_pkg::VIC_GRANT;
					next_gnt_nmi = 1'b0;
					next_gnt_lvl = win_lvl;
					next_vec     = lvl_vector(win_lvl);
				end
			end
			vic_pkg::VIC_GRANT:
			begin
				if (ack_i)
				begin
					next_state = vic_pkg::VIC_SERVE;
					if (gnt_nmi)
					begin
						next_nmi_pend = nmi_event;
						next_nonmaskable_in_service_flag     = 1'b1;
					end
					else
					begin
						next_pend[gnt_lvl] = 1'b0;
						next_mask_serv     = 1'b1;
						next_ie            = 1'b0;
					end
				end
			end
			vic_pkg::VIC_SERVE:
			begin
				if (eos_i)
				begin
					next_state     = vic_pkg::VIC_IDLE;
					next_nonmaskable_in_service_flag      = 1'b0;
					next_mask_serv = 1'b0;
				end
			end
			default:
				next_state = vic_pkg::VIC_IDLE;
		endcase
		next_pend = next_pend | src_evt;
	end

	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			state     <= vic_pkg::VIC_IDLE;
			pend      <= vic_pkg::PEND_RST;
			nmi_pend  <= 1'b0;
			ie        <= 1'b0;
			nonmaskable_in_service_flag      <= 1'b0;
			mask_serv <= 1'b0;
			gnt_nmi   <= 1'b0;
			gnt_lvl   <= 4'h0;
			vec       <= vic_pkg::VEC_RST;
		end
		else
		begin
			state     <= next_state;
			pend      <= next_pend;
			nmi_pend  <= next_nmi_pend;
			ie        <= next_ie;
			nonmaskable_in_service_flag      <= next_nonmaskable_in_service_flag;
			mask_serv <= next_mask_serv;
			gnt_nmi   <= next_gnt_nmi;
			gnt_lvl   <= next_gnt_lvl;
			vec       <= next_vec;
		end
	end

	always_comb
	begin
		irq_o                         = (state == vic_pkg::VIC_GRANT);
		irq_nmi_o                     = gnt_nmi;
		vector_o                      = vec;
		level_o                       = gnt_lvl;
		pending_o                     = pend;
		global_irq_enable_flag_o      = ie;
		nonmaskable_in_service_flag_o = nonmaskable_in_service_flag;
	end
endmodule : vic_ctrl

// *** dv/vic_cpu_model.sv ***
module vic_cpu_model
(
	input  wire logic        core_clk_i, // Core clock
	input  wire logic        rstn_i,     // Reset, active low
	input  wire logic        irq_i,      // Grant request
	input  wire logic [15:0] vector_i,   // Offered vector
	input  wire logic [3:0]  delay_i,    // Cycles before ack
	output logic             ack_o,      // Grant accepted
	output logic             eos_o,      // End of service
	output logic [15:0]      taken_o     // Fetched vector
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] cnt;
	logic [1:0] svc;
	always_ff @(posedge core_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			{cnt, svc, ack_o, eos_o, taken_o} <= '0;
		else
		begin
			ack_o <= 1'b0;
			eos_o <= svc == 2'h1;
			if (ack_o)
			begin
				taken_o <= vector_i;
				svc <= 2'h3;
			end
			else if (svc != 2'h0)
				svc <= svc - 2'h1;
			else if (irq_i)
			begin
				ack_o <= cnt == delay_i;
				cnt <= (cnt == delay_i) ? 4'h0 : cnt + 4'h1;
			end
		end
	end
endmodule : vic_cpu_model

// *** dv/vic_ctrl_sva.sv ***
module vic_ctrl_sva
(
	input wire logic        core_clk_i,                   // Clock
	input wire logic        rstn_i,                       // Reset
	input wire logic        wdt_overflow_i,               // Overflow
	input wire logic        wdt_nmi_mode_i,               // Route
	input wire logic        ack_i,                        // Ack
	input wire logic        eos_i,                        // Service end
	input wire logic        irq_o,                        // Grant
	input wire logic        irq_nmi_o,                    // Grant kind
	input wire logic [15:0] vector_o,                     // Vector
	input wire logic [3:0]  level_o,                      // Level
	input wire logic [13:0] pending_o,                    // Pending
	input wire logic        global_irq_enable_flag_o,     // Enable
	input wire logic        nonmaskable_in_service_flag_o // In service
);
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!rstn_i);
	a_enable_gates: assert property ($rose(irq_o) && !irq_nmi_o |-> global_irq_enable_flag_o)
		else $error("maskable grant while disabled");
	a_lowest_wins: assert property ($rose(irq_o) && !irq_nmi_o |->
		($past(pending_o) << (4'hd - level_o)) == 14'h2000)
		else $error("grant not lowest pending level");
	a_wdt_vector: assert property (irq_o && (irq_nmi_o || level_o == 4'h0) |-> vector_o == 16'h0004)
		else $error("watchdog vector wrong");
	a_wdt_route: assert property (wdt_overflow_i && wdt_nmi_mode_i && !pending_o[0] |=> !pending_o[0])
		else $error("watchdog routed to both paths");
	a_pend_held: assert property (!(ack_i && irq_o) |=> (pending_o & $past(pending_o)) == $past(pending_o))
		else $error("pending dropped without ack");
	a_grant_stands: assert property (irq_o && !ack_i |=> irq_o && $stable(vector_o))
		else $error("grant changed before ack");
	a_nmi_flag: assert property (nonmaskable_in_service_flag_o |=> nonmaskable_in_service_flag_o == !$past(eos_i))
		else $error("service flag wrong");
	a_no_grant_nmi: assert property (nonmaskable_in_service_flag_o |-> !irq_o)
		else $error("grant during service");
endmodule : vic_ctrl_sva

bind vic_ctrl vic_ctrl_sva u_vic_ctrl_sva (.*);

// *** dv/test_vic_ctrl.sv ***
module test_vic_ctrl;
	timeunit 1ns;
	timeprecision 100ps;
	logic core_clk_i, rstn_i, wdt_nmi_mode_i, ie_set_i, ie_clr_i, ack_i, eos_i;
	logic wdt_overflow_i, serial_rx_done_i, serial_3wire_done_i, serial_tx_done_i;
	logic watch_interval_i, watch_main_i, timer16_match_i, timer8a_match_i;
	logic timer8b_match_i, adc_done_i, irq_o, irq_nmi_o;
	logic global_irq_enable_flag_o, nonmaskable_in_service_flag_o;
	logic [3:0] ext_pin_i, key_input_pins_i, level_o, lat;
	logic [7:0] ext_edge_sel_i;
	logic [9:0] src;
	logic [13:0] pending_o;
	logic [15:0] vector_o, taken;
	logic [15:0] vtab [14] = '{16'h0004, 16'h0006, 16'h0008, 16'h000a, 16'h000c, 16'h000e,
		16'h0012, 16'h0014, 16'h0016, 16'h0018, 16'h001a, 16'h001c, 16'h001e, 16'h0020};
	int err_count, compares, cyc;
	assign {wdt_overflow_i, serial_rx_done_i, serial_3wire_done_i, serial_tx_done_i,
		watch_interval_i, timer16_match_i, timer8a_match_i, timer8b_match_i, adc_done_i,
		watch_main_i} = src;
	vic_ctrl dut (.*);
	vic_cpu_model cpu (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .irq_i(irq_o),
		.vector_i(vector_o), .delay_i(lat), .ack_o(ack_i), .eos_o(eos_i), .taken_o(taken));
	task automatic finish_test;
		if (err_count == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : finish_test
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp)
		begin
			err_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : check
	task automatic fire(input logic [9:0] m);
		src = m;
		@(negedge core_clk_i);
		src = 10'h000;
	endtask : fire
	task automatic pulse_ie(input logic [1:0] m);
		{ie_set_i, ie_clr_i} = m;
		@(negedge core_clk_i);
		{ie_set_i, ie_clr_i} = 2'h0;
	endtask : pulse_ie
	task automatic serve(input logic [15:0] vec, input logic [3:0] lvl, input logic nmi);
		int n;
		n = 0;
		while (irq_o !== 1'b1 && n < 40)
		begin
			@(negedge core_clk_i);
			n++;
		end
		check("vector", vec, vector_o);
		check("kind", {15'h0000, nmi}, {15'h0000, irq_nmi_o});
		if (!nmi)
			check("level", {12'h000, lvl}, {12'h000, level_o});
		while (eos_i !== 1'b1 && n < 80)
		begin
			@(negedge core_clk_i);
			n++;
		end
		check("taken", vec, taken);
		check("nonmaskable_in_service_flag", {15'h0000, nmi}, {15'h0000, nonmaskable_in_service_flag_o});
		@(negedge core_clk_i);
		pulse_ie(2'h2);
	endtask : serve
	initial
	begin
		core_clk_i = 1'b0;
		forever #2 core_clk_i = ~core_clk_i;
	end
	always @(posedge core_clk_i)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			err_count++;
			finish_test;
		end
	end
	initial
	begin
		{rstn_i, wdt_nmi_mode_i, ie_set_i, ie_clr_i, src, lat} = '0;
		ext_pin_i = 4'h2;
		key_input_pins_i = 4'hf;
		ext_edge_sel_i = 8'h79;
		repeat (6) @(posedge core_clk_i);
		@(negedge core_clk_i);
		rstn_i = 1'b1;
		check("enable", 16'h0000, {15'h0000, global_irq_enable_flag_o});
		pulse_ie(2'h2);
		pulse_ie(2'h1);
		fire(10'h010);
		repeat (4) @(negedge core_clk_i);
		check("pending", 16'h0100, {2'h0, pending_o});
		check("irq", 16'h0000, {15'h0000, irq_o});
		pulse_ie(2'h2);
		serve(16'h0016, 4'h8, 1'b0);
		lat = 4'h2;
		pulse_ie(2'h1);
		ext_pin_i = 4'hd;
		key_input_pins_i = 4'he;
		fire(10'h3ff);
		repeat (6) @(negedge core_clk_i);
		check("pending", 16'h3fff, {2'h0, pending_o});
		pulse_ie(2'h2);
		for (int i = 0; i < 14; i++)
			serve(vtab[i], i[3:0], 1'b0);
		pulse_ie(2'h1);
		ext_pin_i = 4'h2;
		fire(10'h080);
		repeat (6) @(negedge core_clk_i);
		check("pending", 16'h0028, {2'h0, pending_o});
		pulse_ie(2'h2);
		serve(16'h000a, 4'h3, 1'b0);
		serve(16'h000e, 4'h5, 1'b0);
		lat = 4'h5;
		pulse_ie(2'h1);
		wdt_nmi_mode_i = 1'b1;
		fire(10'h200);
		fire(10'h008);
		@(negedge core_clk_i);
		check("pending", 16'h0200, {2'h0, pending_o});
		serve(16'h0004, 4'h0, 1'b1);
		check("nonmaskable_in_service_flag", 16'h0000, {15'h0000, nonmaskable_in_service_flag_o});
		serve(16'h0018, 4'h9, 1'b0);
		finish_test;
	end
endmodule : test_vic_ctrl
